/* core/psq_pkg.sv */
// package: constants and carrier types of the program sequencer
package psq_pkg;
  localparam int unsigned PC_W      = 11;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ROM_WORDS = 1528;
  localparam logic [10:0] PC_RESET  = 11'h000;
  localparam logic [10:0] PC_ONE    = 11'h001;
  localparam logic [10:0] ADDR_LAST = 11'h5f7;
  localparam logic [15:0] WORD_UNDEF = 16'h0000;
  // power-on fill of the return holder; arbitrary, software sees it as undefined
  localparam logic [10:0] HOLD_INIT = 11'h000;

  typedef enum logic [2:0] {
    PSQ_OP_STEP    = 3'h0,
    PSQ_OP_JUMP    = 3'h1,
    PSQ_OP_CALL    = 3'h2,
    PSQ_OP_RET     = 3'h3,
    PSQ_OP_RETSKIP = 3'h4
  } psq_op_t;

  typedef enum logic [1:0] {
    PSQ_ST_RUN  = 2'h0,
    PSQ_ST_SKIP = 2'h1
  } psq_state_t;

  // command from the decoder
  typedef struct packed {
    logic        valid;
    psq_op_t     op;
    logic [10:0] target;
  } psq_cmd_t;

  // fetched instruction toward the decoder
  typedef struct packed {
    logic        valid;
    logic        skip;
    logic [10:0] addr;
    logic [15:0] word;
  } psq_fetch_t;

  typedef struct packed {
    psq_state_t  fsm;
    logic [10:0] pc;
    logic [10:0] retAddr;
    logic        retValid;
    psq_fetch_t  fetch;
    logic        ceResetMeta;
    logic        ceResetSync;
  } psq_state_all_t;
endpackage

/* core/psq_sequencer.sv */
// module: program counter, return address holder and program store
//
// Contract
// - program store holds 1528 words of 16 bits, one instruction each
// - valid store addresses are 000h through 5f7h inclusive
// - each instruction is one 16-bit word at one address
// - an 11-bit binary counter selects the fetched word
// - direct_jump loads its operand into the counter
// - call loads its operand into the counter, any valid target allowed
// - call saves return address into the holder before loading target
// - subroutine_return and return_with_skip reload counter from the holder
// - power-on and chip-enable reset clear the counter to zero
// - one 11-bit return_address_holder, a single saved level
// - counter reaches 7ffh; fetches above 5f7h give undefined contents
// - holder undefined after power-on, kept through chip-enable reset
`timescale 1ns/10ps
module psq_sequencer (
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 clkEn,
  // chip-enable reset from pin, asynchronous
  input  wire logic                 ceReset,
  // program loading port, same clock
  input  wire logic                 loadWe,
  input  wire logic [10:0]          loadAddr,
  input  wire logic [15:0]          loadData,
  // command from decoder
  input  wire psq_pkg::psq_cmd_t    cmd,
  // outputs
  output      psq_pkg::psq_fetch_t  fetch,
  output      logic [10:0]          pcOut,
  output      logic [10:0]          retAddrOut
);

  // program store; code load port stands in for mask contents
  logic [15:0] rom [0:psq_pkg::ROM_WORDS-1];

  psq_pkg::psq_state_all_t s_q;
  psq_pkg::psq_state_all_t s_d;

  function automatic logic inRange(input logic [10:0] a);
    inRange = (a <= psq_pkg::ADDR_LAST);
  endfunction

  // store writes; out-of-range writes are dropped
  always_ff @(posedge clk) begin
    if (clkEn && loadWe && inRange(loadAddr)) begin
      rom[loadAddr] <= loadData;
    end
  end

  logic [15:0] romWord;
  // region above the store reads a fixed filler value
  always_comb begin
    if (inRange(s_q.pc)) begin
      romWord = rom[s_q.pc];
    end else begin
      romWord = psq_pkg::WORD_UNDEF;
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ceResetMeta = ceReset;
    s_d.ceResetSync = s_q.ceResetMeta;
    s_d.fetch.valid = 1'b0;
    if (s_q.ceResetSync) begin
      s_d.pc = psq_pkg::PC_RESET;
      s_d.fsm = psq_pkg::PSQ_ST_RUN; // holder kept
    end else if (cmd.valid) begin
      s_d.fetch.valid = 1'b1;
      s_d.fetch.addr = s_q.pc;
      s_d.fetch.word = romWord;
      s_d.fetch.skip = (s_q.fsm == psq_pkg::PSQ_ST_SKIP);
      s_d.fsm = psq_pkg::PSQ_ST_RUN;
      case (cmd.op)
        psq_pkg::PSQ_OP_JUMP: begin
          s_d.pc = cmd.target;
        end
        psq_pkg::PSQ_OP_CALL: begin
          s_d.retAddr = s_q.pc + psq_pkg::PC_ONE;
          s_d.retValid = 1'b1;
          s_d.pc = cmd.target;
        end
        psq_pkg::PSQ_OP_RET: begin
          s_d.pc = s_q.retAddr;
        end
        psq_pkg::PSQ_OP_RETSKIP: begin
          s_d.pc = s_q.retAddr;
          s_d.fsm = psq_pkg::PSQ_ST_SKIP;
        end
        default: begin
          s_d.pc = s_q.pc + psq_pkg::PC_ONE;
        end
      endcase
    end
  end

  // state register: one process owns every field, so each bit has one driver;
  // the holder gets an arbitrary constant at power-on, which software must
  // still treat as undefined until the first call has filled it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q.fsm         <= psq_pkg::PSQ_ST_RUN;
      s_q.pc          <= psq_pkg::PC_RESET;
      s_q.retAddr     <= psq_pkg::HOLD_INIT;
      s_q.retValid    <= 1'b0;
      s_q.fetch       <= '0;
      s_q.ceResetMeta <= 1'b0;
      s_q.ceResetSync <= 1'b0;
    end else if (clkEn) begin
      s_q <= s_d; // low enable freezes every field at once
    end
  end

  // outputs come straight from the state register
  assign fetch      = s_q.fetch;
  assign pcOut      = s_q.pc;
  assign retAddrOut = s_q.retAddr;

  // a command counts only while enabled and not held in chip-enable reset
  logic taken;
  assign taken = clkEn && cmd.valid && !s_q.ceResetSync;

  // checks: all on the rising edge, switched off during power-on reset;
  // each looks one edge after its trigger; the skip check looks two edges after the return_with_skip

  // a jump puts its operand into the counter unchanged
  // any 11-bit operand is loaded; keeping it in range is software's job
  property p_jump;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_JUMP)
        |=> (s_q.pc == $past(cmd.target));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  // a call puts its operand into the counter
  // the target range is the same as for a jump
  property p_call;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_CALL)
        |=> (s_q.pc == $past(cmd.target));
  endproperty
  a_call: assert property (p_call) else $error("call target not loaded");

  // a call saves the address after its own in the holder
  // the old holder value is lost, as there is only one level
  property p_save;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_CALL)
        |=> (s_q.retAddr == $past(s_q.pc) + psq_pkg::PC_ONE);
  endproperty
  a_save: assert property (p_save) else $error("return address not saved");

  // both returns reload the counter from the holder
  // the holder itself is left as it was
  property p_ret;
    @(posedge clk) disable iff (!rstn)
      (taken && (cmd.op == psq_pkg::PSQ_OP_RET || cmd.op == psq_pkg::PSQ_OP_RETSKIP))
        |=> (s_q.pc == $past(s_q.retAddr));
  endproperty
  a_ret: assert property (p_ret) else $error("return address not restored");

  // the step command steps the counter by one; the other default ops are not checked
  // the sum is taken at 11 bits, so 7ffh steps to 000h
  property p_step;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_STEP)
        |=> (s_q.pc == $past(s_q.pc) + psq_pkg::PC_ONE);
  endproperty
  a_step: assert property (p_step) else $error("counter did not advance");

  // chip-enable reset clears the counter on every enabled edge
  // it is seen two edges late, through the pin synchroniser
  property p_ce;
    @(posedge clk) disable iff (!rstn)
      (clkEn && s_q.ceResetSync) |=> (s_q.pc == psq_pkg::PC_RESET);
  endproperty
  a_ce: assert property (p_ce) else $error("chip-enable reset wrong");

  // chip-enable reset leaves the holder alone
  // a return after it still goes to the saved address
  property p_cekeep;
    @(posedge clk) disable iff (!rstn)
      (clkEn && s_q.ceResetSync) |=> $stable(s_q.retAddr);
  endproperty
  a_cekeep: assert property (p_cekeep) else $error("holder lost on chip-enable reset");

  // chip-enable reset also drops a pending skip
  // so the word at address zero always executes
  property p_cefsm;
    @(posedge clk) disable iff (!rstn)
      (clkEn && s_q.ceResetSync) |=> (s_q.fsm == psq_pkg::PSQ_ST_RUN);
  endproperty
  a_cefsm: assert property (p_cefsm) else $error("skip kept over reset");

  // commands during chip-enable reset are dropped, no fetch is shown
  // the decoder gets no answer and must not wait for one
  property p_refuse;
    @(posedge clk) disable iff (!rstn)
      (clkEn && s_q.ceResetSync) |=> !fetch.valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command taken in reset");

  // the word fetched right after return_with_skip is flagged
  // the flag sits on the fetch, the decoder turns it into a no-op
  property p_skip;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_RETSKIP) ##1 taken |=> fetch.skip;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not flagged");

  // return_with_skip arms the skip state
  // it stays armed across idle cycles until the next command
  property p_arm;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_RETSKIP) |=> (s_q.fsm == psq_pkg::PSQ_ST_SKIP);
  endproperty
  a_arm: assert property (p_arm) else $error("skip state not armed");

  // any other command leaves the skip state disarmed
  // a skip suppresses exactly one word, never two
  property p_disarm;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op != psq_pkg::PSQ_OP_RETSKIP) |=> (s_q.fsm == psq_pkg::PSQ_ST_RUN);
  endproperty
  a_disarm: assert property (p_disarm) else $error("skip state stuck");

  // without an armed skip no fetch carries the flag
  // a false flag would silently lose an instruction
  property p_noskip;
    @(posedge clk) disable iff (!rstn)
      (taken && s_q.fsm == psq_pkg::PSQ_ST_RUN) |=> !fetch.skip;
  endproperty
  a_noskip: assert property (p_noskip) else $error("spurious skip flag");

  // fetches above the store return the filler word
  // code that runs there executes whatever the filler decodes to
  property p_undef;
    @(posedge clk) disable iff (!rstn)
      (taken && !inRange(s_q.pc)) |=> (fetch.word == psq_pkg::WORD_UNDEF);
  endproperty
  a_undef: assert property (p_undef) else $error("upper region not filler");

  // every taken command shows a fetch of the word at the old counter
  // the fetch is one cycle behind the counter, by design
  property p_fetchaddr;
    @(posedge clk) disable iff (!rstn)
      taken |=> fetch.valid && (fetch.addr == $past(s_q.pc));
  endproperty
  a_fetchaddr: assert property (p_fetchaddr) else $error("fetch address wrong");

  // an idle enabled cycle shows no fetch and keeps the counter
  // the counter only moves on commands or reset
  property p_idle;
    @(posedge clk) disable iff (!rstn)
      (clkEn && !cmd.valid && !s_q.ceResetSync) |=> !fetch.valid && $stable(s_q.pc);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved while idle");

  // with the enable low nothing moves, fetch included
  // a frozen fetch pulse stays shown until the first enabled edge clears it
  property p_freeze;
    @(posedge clk) disable iff (!rstn)
      !clkEn |=> $stable(s_q.pc) && $stable(fetch) && $stable(s_q.retAddr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // only a call writes the single holder
  // returns read it; returns, jumps and steps leave it unchanged
  property p_holdkeep;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op != psq_pkg::PSQ_OP_CALL) |=> $stable(s_q.retAddr);
  endproperty
  a_holdkeep: assert property (p_holdkeep) else $error("holder changed without call");

  // after a call the holder is marked as filled
  // nothing clears the mark except power-on reset
  property p_filled;
    @(posedge clk) disable iff (!rstn)
      (taken && cmd.op == psq_pkg::PSQ_OP_CALL) |=> s_q.retValid;
  endproperty
  a_filled: assert property (p_filled) else $error("holder not marked filled");

endmodule // psq_sequencer

/* dv/psq_decoder_model.sv */
// decoder-side model that turns bench requests into sequencer commands
`timescale 1ns/10ps
module psq_decoder_model (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // requested instruction
  input  wire logic          reqValid,
  input  wire logic [2:0]    reqOp,
  input  wire logic [10:0]   reqTarget,
  // command toward the sequencer
  output psq_pkg::psq_cmd_t  cmd
);
  logic callOpen;
  logic skipNext;
  // a skipped word runs as a step; no nesting, so returns need an open call
  always_comb begin
    cmd = {reqValid, psq_pkg::psq_op_t'(reqOp), reqTarget};
    if (skipNext) cmd.op = psq_pkg::PSQ_OP_STEP;
    else if (cmd.op == psq_pkg::PSQ_OP_CALL && callOpen) cmd.op = psq_pkg::PSQ_OP_STEP;
    else if (cmd.op inside {psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETSKIP} && !callOpen)
      cmd.op = psq_pkg::PSQ_OP_STEP;
  end
  // track the single open call level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      callOpen <= 1'b0;
      skipNext <= 1'b0;
    end else if (cmd.valid) begin
      skipNext <= cmd.op == psq_pkg::PSQ_OP_RETSKIP;
      if (cmd.op == psq_pkg::PSQ_OP_CALL) callOpen <= 1'b1;
      else if (cmd.op inside {psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETSKIP}) callOpen <= 1'b0;
    end
  end
endmodule // psq_decoder_model

/* dv/testbench.sv */
// self-checking bench for the program sequencer
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, rstn = 1'b0, ceReset = 1'b0, loadWe = 1'b0, reqValid = 1'b0;
  logic [10:0] loadAddr = 11'h000, reqTarget = 11'h000, ePc, eRet, pcOut, retAddrOut;
  logic [15:0] loadData = 16'h0000;
  logic clkEn = 1'b1;
  logic [2:0] reqOp = 3'h0;
  logic eSkip;
  int failures = 0, n_checks = 0;
  psq_pkg::psq_cmd_t cmd, c;
  psq_pkg::psq_fetch_t fetch;
  always #5 clk = ~clk;
  psq_decoder_model mdl (.clk(clk), .rstn(rstn), .reqValid(reqValid), .reqOp(reqOp),
    .reqTarget(reqTarget), .cmd(cmd));
  psq_sequencer dut (.clk(clk), .rstn(rstn), .clkEn(clkEn), .ceReset(ceReset), .loadWe(loadWe),
    .loadAddr(loadAddr), .loadData(loadData), .cmd(cmd), .fetch(fetch), .pcOut(pcOut),
    .retAddrOut(retAddrOut));
  // store image: low address bits repeated; upper region reads fixed
  function automatic logic [15:0] wordAt(logic [10:0] ad);
    return (ad <= psq_pkg::ADDR_LAST) ? {ad[4:0], ad} : psq_pkg::WORD_UNDEF;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one instruction, driven after a falling edge and checked one edge later
  task automatic run(logic [2:0] op, logic [10:0] tgt);
    reqValid = 1'b1;
    reqOp = op;
    reqTarget = tgt;
    #1 c = cmd;
    @(negedge clk);
    chk(fetch.valid, 1'b1);
    chk(fetch.addr, ePc);
    chk(fetch.word, wordAt(ePc));
    chk(fetch.skip, eSkip);
    case (c.op)
      psq_pkg::PSQ_OP_JUMP: ePc = c.target;
      psq_pkg::PSQ_OP_CALL: begin eRet = ePc + 11'h001; ePc = c.target; end
      psq_pkg::PSQ_OP_RET, psq_pkg::PSQ_OP_RETSKIP: ePc = eRet;
      default: ePc = ePc + 11'h001;
    endcase
    eSkip = c.op == psq_pkg::PSQ_OP_RETSKIP;
    chk(pcOut, ePc);
    if (!$isunknown(eRet)) chk(retAddrOut, eRet);
  endtask
  initial begin
    void'($urandom(32'h43c23c14));
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    chk(pcOut, psq_pkg::PC_RESET);
    for (int i = 0; i < 2048; i++) begin
      loadWe = 1'b1;
      loadAddr = i[10:0];
      loadData = {loadAddr[4:0], loadAddr};
      @(negedge clk);
    end
    loadWe = 1'b0;
    {ePc, eRet, eSkip} = {11'h000, 11'hxxx, 1'b0};
    $display("test load done");
    // edge of store, undefined region, wrap, call and both returns, odd op
    run(3'h1, 11'h5f7); run(3'h0, 11'h000); run(3'h1, 11'h7ff); run(3'h0, 11'h000);
    run(3'h2, 11'h5f7); run(3'h4, 11'h000); run(3'h0, 11'h000); run(3'h2, 11'h000);
    run(3'h3, 11'h000); run(3'h7, 11'h000);
    $display("test corners done");
    for (int i = 0; i < 400; i++) begin
      run(3'($urandom_range(0, 7)), 11'($urandom_range(0, 32'h5f7)));
      if (i == 100) begin
        reqValid = 1'b0;
        clkEn = 1'b0;
        repeat (3) @(negedge clk);
        chk(pcOut, ePc);
        chk(fetch.valid, 1'b1);
        clkEn = 1'b1;
        @(negedge clk);
        chk(fetch.valid, 1'b0);
        chk(pcOut, ePc);
      end
      if (i == 200) begin
        reqValid = 1'b0;
        ceReset = 1'b1;
        repeat (4) @(negedge clk);
        ceReset = 1'b0;
        repeat (3) @(negedge clk);
        {ePc, eSkip} = {11'h000, 1'b0};
        chk(fetch.valid, 1'b0);
        chk(pcOut, psq_pkg::PC_RESET);
        if (!$isunknown(eRet)) chk(retAddrOut, eRet);
      end
    end
    $display("test random done");
    end_sim();
  end
  initial begin
    #100us;
    failures++;
    end_sim();
  end
endmodule // testbench
